// ### hdl/cwc_top.v
`include "cwc_consts.vh"

module cwc_top #(
   parameter CNT_W = `CWC_CNT_W,
   parameter [CNT_W-1:0] SAMPLE_POINT = `CWC_SAMPLE_POINT,
   parameter [CNT_W-1:0] START_MIN = `CWC_START_MIN
) (
   input wire aclk,
   input wire aresetn,
   input wire [`CWC_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`CWC_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire cec_line_in,
   input wire fs_clk_in,
   input wire reception_enable,
   output reg wave_error,
   output reg rx_bit_valid,
   output reg rx_bit_value,
   output wire irq
);

   // ==========================================================
   // Helpers

   // Latest limit: base plus code
   function [CNT_W-1:0] late_lim;
      input [CNT_W-1:0] base;
      input [2:0] code;
      begin
         late_lim = base + {{(CNT_W-3){1'b0}}, code};
      end
   endfunction

   // Earliest limit: base minus code
   function [CNT_W-1:0] early_lim;
      input [CNT_W-1:0] base;
      input [2:0] code;
      begin
         early_lim = base - {{(CNT_W-3){1'b0}}, code};
      end
   endfunction

   // Merge write data under byte strobes
   function [31:0] strobe_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer i;
      begin
         strobe_merge = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               strobe_merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   // ==========================================================
   // Pin synchronisers and rise timer
   wire [1:0] pins_s;
   wire rise_pulse;
   wire [CNT_W-1:0] rise_count;

   cwc_sync #(
      .WIDTH(2)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({fs_clk_in, cec_line_in}),
      .sync_out(pins_s)
   );

   cwc_rise_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .line_s(pins_s[0]),
      .fs_s(pins_s[1]),
      .rise_pulse(rise_pulse),
      .rise_count(rise_count)
   );

   // ==========================================================
   // Registers
   reg [31:0] limits;
   reg [`CWC_IRQ_W-1:0] irq_stat;
   reg [`CWC_IRQ_W-1:0] irq_mask;
   reg [CNT_W-1:0] last_count;
   reg last_value;
   reg [7:0] err_count;

   wire check_en;
   wire [2:0] zero_rise_latest;
   wire [2:0] zero_rise_earliest;
   wire [2:0] one_rise_latest;
   wire [2:0] one_rise_earliest;
   wire waveform_check_enable;

   assign zero_rise_latest = limits[`CWC_ZERO_LATE_LSB +: 3];
   assign zero_rise_earliest = limits[`CWC_ZERO_EARLY_LSB +: 3];
   assign one_rise_latest = limits[`CWC_ONE_LATE_LSB +: 3];
   assign one_rise_earliest = limits[`CWC_ONE_EARLY_LSB +: 3];
   assign waveform_check_enable = limits[`CWC_ENABLE_BIT];

   // ==========================================================
   // Waveform check
   wire [CNT_W-1:0] zero_late;
   wire [CNT_W-1:0] zero_early;
   wire [CNT_W-1:0] one_late;
   wire [CNT_W-1:0] one_early;
   wire is_start;
   wire bit_val;
   wire zero_bad;
   wire one_bad;
   wire data_bit;
   wire bad_bit;

   assign zero_late = late_lim(`CWC_ZERO_LATE_BASE, zero_rise_latest);
   assign zero_early = early_lim(`CWC_ZERO_EARLY_BASE, zero_rise_earliest);
   assign one_late = late_lim(`CWC_ONE_LATE_BASE, one_rise_latest);
   assign one_early = early_lim(`CWC_ONE_EARLY_BASE, one_rise_earliest);

   // Long lows are start bits and belong to another checker
   assign is_start = (rise_count >= START_MIN);
   // Value as sampled at the nominal data sample point
   assign bit_val = (rise_count <= SAMPLE_POINT);
   assign zero_bad = (rise_count < zero_early) || (rise_count > zero_late);
   assign one_bad = (rise_count < one_early) || (rise_count > one_late);
   assign data_bit = rise_pulse && !is_start && reception_enable;
   assign check_en = waveform_check_enable;
   // compare against limits of this value
   assign bad_bit = data_bit && check_en && (bit_val ? one_bad : zero_bad);

   // Bit report and error pulse outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         wave_error <= 1'b0;
         rx_bit_valid <= 1'b0;
         rx_bit_value <= 1'b0;
      end else begin
         wave_error <= bad_bit;
         rx_bit_valid <= data_bit;
         if (data_bit) begin
            rx_bit_value <= bit_val;
         end
      end
   end

   // Last measurement and saturating error tally
   always @(posedge aclk) begin
      if (!aresetn) begin
         last_count <= {CNT_W{1'b0}};
         last_value <= 1'b0;
         err_count <= 8'h00;
      end else begin
         if (data_bit) begin
            last_count <= rise_count;
            last_value <= bit_val;
         end
         if (bad_bit && !(&err_count)) begin
            err_count <= err_count + 8'h01;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite write path
   reg aw_held;
   reg w_held;
   reg [`CWC_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go;
   wire [31:0] lim_new;
   wire [31:0] clr_bits;

   // Each channel is taken once and held until the response
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign lim_new = strobe_merge(limits, w_data, w_strb);
   assign clr_bits = strobe_merge(32'h0000_0000, w_data, w_strb);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`CWC_ADDR_W{1'b0}};
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CWC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
               `CWC_OFS_LIMITS,
               `CWC_OFS_IRQ_STAT,
               `CWC_OFS_IRQ_MASK,
               `CWC_OFS_MEAS: s_axi_bresp <= `CWC_RESP_OKAY;
               default: s_axi_bresp <= `CWC_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Limits and mask registers; reserved bits stay zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         limits <= `CWC_LIMITS_RST;
         irq_mask <= `CWC_IRQ_RST;
      end else if (wr_go) begin
         if (aw_addr == `CWC_OFS_LIMITS) begin
            limits <= lim_new & `CWC_LIMITS_MASK;
         end
         if (aw_addr == `CWC_OFS_IRQ_MASK && w_strb[0]) begin
            irq_mask <= w_data[`CWC_IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // Interrupt status: a new event wins over a same-cycle clear
   reg [`CWC_IRQ_W-1:0] next_irq_stat;
   reg [`CWC_IRQ_W-1:0] irq_set;

   always @* begin
      irq_set = {`CWC_IRQ_W{1'b0}};
      irq_set[`CWC_IRQ_WAVE_ERR] = bad_bit;
      irq_set[`CWC_IRQ_BIT_DONE] = data_bit;
      next_irq_stat = irq_stat;
      if (wr_go && aw_addr == `CWC_OFS_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~clr_bits[`CWC_IRQ_W-1:0];
      end
      next_irq_stat = next_irq_stat | irq_set;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= `CWC_IRQ_RST;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ==========================================================
   // AXI4-Lite read path
   reg [31:0] rd_val;
   reg rd_ok;

   // Single-cycle answer; no new address while data waits
   assign s_axi_arready = !s_axi_rvalid;

   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `CWC_OFS_LIMITS: rd_val = limits;
         `CWC_OFS_IRQ_STAT: rd_val[`CWC_IRQ_W-1:0] = irq_stat;
         `CWC_OFS_IRQ_MASK: rd_val[`CWC_IRQ_W-1:0] = irq_mask;
         `CWC_OFS_MEAS: rd_val = {15'h0000, last_value, err_count,
                                  last_count};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CWC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ### hdl/cwc_consts.vh
`ifndef CWC_CONSTS_VH
`define CWC_CONSTS_VH

// ==========================================================
// Register map (byte addresses on the register bus)
`define CWC_ADDR_W 4
`define CWC_OFS_LIMITS 4'h0
`define CWC_OFS_IRQ_STAT 4'h4
`define CWC_OFS_IRQ_MASK 4'h8
`define CWC_OFS_MEAS 4'hC

// ==========================================================
// Limits register fields
`define CWC_ZERO_LATE_LSB 20
`define CWC_ZERO_EARLY_LSB 16
`define CWC_ONE_LATE_LSB 12
`define CWC_ONE_EARLY_LSB 8
`define CWC_ENABLE_BIT 0
`define CWC_LIMITS_MASK 32'h0077_7701
`define CWC_LIMITS_RST 32'h0000_0000

// ==========================================================
// Interrupt status and mask bits
`define CWC_IRQ_W 2
`define CWC_IRQ_WAVE_ERR 0
`define CWC_IRQ_BIT_DONE 1
`define CWC_IRQ_RST 2'h0

// ==========================================================
// Base rise times, in sampling clock periods, and the counter width
`define CWC_ZERO_LATE_BASE 8'h38
`define CWC_ZERO_EARLY_BASE 8'h2B
`define CWC_ONE_LATE_BASE 8'h1A
`define CWC_ONE_EARLY_BASE 8'h0D
`define CWC_SAMPLE_POINT 8'h22
`define CWC_START_MIN 8'h64
`define CWC_CNT_W 8

// ==========================================================
// Bus answers
`define CWC_RESP_OKAY 2'h0
`define CWC_RESP_SLVERR 2'h2

`endif

// ### hdl/cwc_sync.v
// ==========================================================
// Two-stage synchroniser for pin inputs
module cwc_sync #(
   parameter WIDTH = 1
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // First stage feeds only the second one
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ### hdl/cwc_rise_timer.v
`include "cwc_consts.vh"

// ==========================================================
// Measures the low time of each bit in sampling clock periods
module cwc_rise_timer #(
   parameter CNT_W = `CWC_CNT_W
) (
   input wire aclk,
   input wire aresetn,
   input wire line_s,
   input wire fs_s,
   output reg rise_pulse,
   output reg [CNT_W-1:0] rise_count
);

   reg line_d;
   reg fs_d;
   reg armed;
   reg [CNT_W-1:0] cnt;
   wire fall_edge;
   wire rise_edge;
   wire fs_tick;

   assign fall_edge = line_d & ~line_s;
   assign rise_edge = ~line_d & line_s;
   assign fs_tick = fs_s & ~fs_d;

   // Edge history; line idles high
   always @(posedge aclk) begin
      if (!aresetn) begin
         line_d <= 1'b1;
         fs_d <= 1'b1;
      end else begin
         line_d <= line_s;
         fs_d <= fs_s;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         armed <= 1'b0;
         cnt <= {CNT_W{1'b0}};
         rise_pulse <= 1'b0;
         rise_count <= {CNT_W{1'b0}};
      end else begin
         rise_pulse <= 1'b0;
         if (fall_edge) begin
            armed <= 1'b1;
            cnt <= {CNT_W{1'b0}};
         end else if (rise_edge && armed) begin
            armed <= 1'b0;
            rise_pulse <= 1'b1;
            rise_count <= cnt;
         end else if (fs_tick && armed && !(&cnt)) begin
            // Saturates so a stuck-low line never wraps
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ### tb/cwc_chk.sv
// ==========================================
// Port checker for the waveform block
module cwc_chk (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic wave_error,
   input logic rx_bit_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Reset blanks every answer one edge later
   a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !wave_error && !rx_bit_valid)
      else $error("outputs busy under reset");
   a_err_has_bit: assert property (wave_error |-> rx_bit_valid)
      else $error("error without a measured bit");
   a_err_pulse: assert property (wave_error |=> !wave_error)
      else $error("error pulse too long");
   a_bit_pulse: assert property (rx_bit_valid |=> !rx_bit_valid)
      else $error("bit pulse too long");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_refuse: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule

// ### tb/cwc_line_model.sv
// ==========================================
// Far side of the control line
module cwc_line_model (
   input logic aclk,
   input logic start,
   input logic [7:0] nedges,
   output logic line,
   output logic fs_clk,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph = 3'h0;
   // Sampling clock runs free, eight aclk a period
   always @(posedge aclk) ph <= ph + 3'h1;
   assign fs_clk = (ph < 3'h4);
   // Mid high phase, so the count never hinges on edge alignment
   task mid_high;
      begin
         @(posedge aclk);
         while (ph != 3'h2) @(posedge aclk);
      end
   endtask
   // Line low for nedges fs rises; the pull-up returns it high
   initial begin
      line = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (start) begin
            busy <= 1'b1;
            mid_high;
            line <= 1'b0;
            repeat (nedges) mid_high;
            line <= 1'b1;
            repeat (40) @(posedge aclk);
            busy <= 1'b0;
         end
      end
   end
endmodule

// ### tb/cwc_rx_waveform_checker_bench.sv
// ==========================================
// Bench top
module cwc_rx_waveform_checker_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, rx_en, start, line, fs, busy, irq;
   logic awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
   logic awready, wready, arready, wave_error, bit_valid, bit_value;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, lfsr, lim;
   logic [1:0] bresp, rresp;
   logic [7:0] nedges;
   logic [2:0] c_zl, c_ze, c_ol, c_oe;
   logic en, seen, val, err;
   integer mismatches, check_count, p, k, lo1, hi1, lo0, hi0, ecount;
   cwc_top i_cwc_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cec_line_in(line),
      .fs_clk_in(fs), .reception_enable(rx_en), .wave_error(wave_error),
      .rx_bit_valid(bit_valid), .rx_bit_value(bit_value), .irq(irq));
   cwc_line_model i_cwc_line_model (.aclk(aclk), .start(start),
      .nedges(nedges), .line(line), .fs_clk(fs), .busy(busy));
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
   endfunction
   task chk(input string what, input logic [31:0] got,
            input logic [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task fail_wait(input string what);
      begin
         chk(what, 1, 0);
         stop_test;
      end
   endtask
   // Handshakes are judged on values held just before the edge
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      integer t;
      begin
         b_hs = 1'b0;
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         for (t = 0; t < 100 && !b_hs; t = t + 1) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
         end
         if (!b_hs) fail_wait("write wait");
         chk("bresp", r, 0);
      end
   endtask
   task axi_rd(input logic [3:0] a, output logic [31:0] d);
      logic ar_hs, r_hs;
      logic [1:0] rr;
      integer t;
      begin
         r_hs = 1'b0;
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         for (t = 0; t < 100 && !r_hs; t = t + 1) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid & rready;
            d = rdata;
            rr = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
         end
         if (!r_hs) fail_wait("read wait");
         chk("rresp", rr, 0);
      end
   endtask
   // One low pulse from the far side, then the model's verdict
   task run_bit(input integer nb);
      logic e_seen, e_val, e_err;
      integer t;
      begin
         seen = 1'b0;
         val = 1'b0;
         err = 1'b0;
         @(posedge aclk);
         // Expect after the edge, so a just-changed enable is seen
         e_seen = rx_en && nb < 100;
         e_val = nb <= 34;
         e_err = e_seen && en &&
            (e_val ? (nb < lo1 || nb > hi1) : (nb < lo0 || nb > hi0));
         if (e_err) ecount = ecount + 1;
         nedges <= nb[7:0];
         start <= 1'b1;
         @(posedge aclk);
         start <= 1'b0;
         for (t = 0; t < 2000 && (t < 3 || busy); t = t + 1) begin
            @(negedge aclk);
            if (bit_valid === 1'b1) seen = 1'b1;
            if (bit_valid === 1'b1) val = bit_value;
            if (wave_error === 1'b1) err = 1'b1;
         end
         if (busy) fail_wait("bit wait");
         chk("bit seen", seen, e_seen);
         if (e_seen) chk("bit value", val, e_val);
         chk("wave error", err, e_err);
         axi_rd(4'hC, rd);
         if (e_seen) chk("rise count", rd[7:0], nb);
         if (e_seen) chk("last value", rd[16], e_val);
         chk("error count", rd[15:8], ecount);
         axi_rd(4'h4, rd);
         chk("irq status", rd[1:0], {e_seen, e_err});
         chk("irq line", irq, e_err);
         axi_wr(4'h4, 32'h3);
      end
   endtask
   // Main sequence
   initial begin
      {aresetn, rx_en, start, awvalid, wvalid, bready} = 6'h0;
      {arvalid, rready, awaddr, araddr, nedges, wdata} = 50'h0;
      {mismatches, check_count, en} = 65'h0;
      ecount = 0;
      lfsr = 32'h53E6_6A19;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(4'h0, rd);
      chk("limits reset", rd, 32'h0);
      axi_rd(4'h8, rd);
      chk("mask reset", rd, 32'h0);
      axi_wr(4'h0, 32'hFFFF_FFFF);
      axi_rd(4'h0, rd);
      chk("limits fields", rd, 32'h0077_7701);
      axi_wr(4'h8, 32'h1);
      for (p = 0; p < 4; p = p + 1) begin
         lfsr = lfsr_next(lfsr);
         {c_zl, c_ze, c_ol, c_oe} = p == 0 ? 12'h0 :
            p == 1 ? 12'hFFF : lfsr[11:0];
         en = (p != 3);
         lim = {9'h0, c_zl, 1'b0, c_ze, 1'b0, c_ol, 1'b0, c_oe, 7'h0, en};
         rx_en <= 1'b0;
         axi_wr(4'h0, lim);
         axi_rd(4'h0, rd);
         chk("limits readback", rd, lim);
         rx_en <= 1'b1;
         lo1 = 13 - c_oe;
         hi1 = 26 + c_ol;
         lo0 = 43 - c_ze;
         hi0 = 56 + c_zl;
         // Each limit and its neighbour outside
         for (k = 0; k < 8; k = k + 1)
            run_bit(k < 2 ? lo1 - 1 + k : k < 4 ? hi1 - 2 + k :
               k < 6 ? lo0 - 5 + k : hi0 - 6 + k);
      end
      rx_en <= 1'b0;
      run_bit(20);
      rx_en <= 1'b1;
      run_bit(100);
      stop_test;
   end
endmodule
bind cwc_top cwc_chk i_cwc_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .wave_error(wave_error), .rx_bit_valid(rx_bit_valid));
